// ---- design/smcg_pkg.sv ----
`default_nettype none
package smcg_pkg;
	// sleep mode select encoding
	typedef enum logic [1:0] {
		SMCG_MODE_IDLE = 2'h0,
		SMCG_MODE_NOISE = 2'h1,
		SMCG_MODE_PDOWN = 2'h2,
		SMCG_MODE_STBY = 2'h3
	} smcg_mode_t;

	// control register field positions
	localparam int SMCG_MODE_HI = 6;
	localparam int SMCG_MODE_LO = 5;
	localparam int SMCG_ARM_BIT = 4;
	localparam logic [7:0] SMCG_CTRL_RESET = 8'h00;
	localparam logic [7:0] SMCG_CTRL_WMASK = 8'h70;

	// power reduction register
	localparam logic [7:0] SMCG_PRR_OFFSET = 8'h34;
	localparam logic [7:0] SMCG_PRR_RESET = 8'h00;
	localparam logic [7:0] SMCG_PRR_WMASK = 8'h7F;
	localparam int SMCG_PR_TWI = 6;
	localparam int SMCG_PR_TIM1 = 5;
	localparam int SMCG_PR_TIM0 = 4;
	localparam int SMCG_PR_USI = 3;
	localparam int SMCG_PR_SER1 = 2;
	localparam int SMCG_PR_SER0 = 1;
	localparam int SMCG_PR_ADC = 0;

	// timing, in core_clk cycles
	localparam logic [3:0] SMCG_HOLD_CYCLES = 4'h4;
	localparam logic [3:0] SMCG_STBY_WAKE_CYCLES = 4'h6;
	localparam logic [15:0] SMCG_OSC_START_RESET = 16'h0010;
	localparam logic [3:0] SMCG_SYNC_RESET = 4'h0;
endpackage
`default_nettype wire

// ---- design/smcg_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
// three-stage synchroniser: output changes once stages two and three agree
module smcg_sync #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// data
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] stage2;
	logic [WIDTH-1:0] stage3;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			stage1 <= '0;
			stage2 <= '0;
			stage3 <= '0;
		end else begin
			stage1 <= async_in;
			stage2 <= stage1;
			stage3 <= stage2;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			sync_out <= '0;
		end else begin
			for (int i = 0; i < WIDTH; i++) begin
				if (stage2[i] == stage3[i]) begin
					sync_out[i] <= stage3[i];
				end
			end
		end
	end
endmodule
`default_nettype wire

// ---- design/smcg_ctrl.sv ----
`timescale 1ns/1ps
`default_nettype none
// How it works
// - idle stops cpu and flash clocks; oscillator, io and converter clocks run.
// - noise mode stops io, cpu and flash; oscillator and converter clock run.
// - power-down stops oscillator and all generated clocks.
// - standby equals power-down but oscillator runs; wake in six cycles.
// - sleep entered only with arm bit set and sleep instruction; mode bits choose.
// - enabled interrupt wakes; cpu held four cycles beyond start-up, then handler.
// - register file and data memory untouched across sleep.
// - reset during sleep wakes and restarts from reset vector.
// - idle accepts every enabled interrupt as wake source.
// - noise mode wake set: resets, level, pin change, converter, memory, serial detectors.
// - power-down and standby ignore converter and memory-ready wake.
// - deeper modes: level irq zero, pin change, watchdog, start frame, start condition, address match only.
// - entering idle or noise mode with converter enabled starts a conversion.
// - comparator disable bit powers comparator down and removes its wake.
// - stopped peripheral freezes, ignores register access, keeps resources.
// - clearing stop bit restarts clock, continuing from frozen state.
// - stop bits act in active and idle; deeper modes stop clocks anyway.
// - converter stays enabled in sleep; first conversion after re-enable is extended.
// - mode field bits 6:5: 0 idle, 1 noise, 2 power-down, 3 standby.
// - power reduction register resets to zero; bit seven reads zero.
module smcg_ctrl #(
	parameter logic [15:0] OSC_START_CYCLES = smcg_pkg::SMCG_OSC_START_RESET
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// control register write port from the core
	input wire logic mcu_ctrl_wr,
	input wire logic [7:0] mcu_ctrl_wdata,
	output logic [7:0] mcu_control_reg,
	// power reduction register port from the core
	input wire logic pr_wr,
	input wire logic [7:0] pr_wdata,
	output logic [7:0] power_reduction_reg,
	// core handshake
	input wire logic sleep_instr,
	output logic cpu_halt,
	output logic sleeping,
	output logic wake_irq,
	output logic wake_reset,
	// converter and comparator
	input wire logic adc_enabled,
	input wire logic comparator_disable_bit,
	output logic adc_start_conv,
	output logic adc_extended_next,
	output logic comparator_power_en,
	// wake sources from pins and asynchronous detectors
	input wire logic external_irq_zero,
	input wire logic pin_change_irq,
	input wire logic wdt_irq,
	input wire logic serial_start_frame,
	input wire logic usi_start_cond,
	input wire logic twi_addr_match,
	// wake sources from synchronous logic
	input wire logic irq_any_enabled,
	input wire logic ext_irq_level_mode,
	input wire logic adc_done_irq,
	input wire logic mem_ready_irq,
	input wire logic comparator_irq,
	// clock domain gates
	output logic osc_en,
	output logic clk_cpu_en,
	output logic clk_flash_en,
	output logic clk_io_en,
	output logic clk_adc_en,
	// per-peripheral clock gates
	output logic clk_twi_en,
	output logic clk_tim1_en,
	output logic clk_tim0_en,
	output logic clk_usi_en,
	output logic clk_ser1_en,
	output logic clk_ser0_en,
	output logic clk_conv_en,
	// register access allowed to peripherals
	output logic [6:0] periph_access_en
);
	typedef enum logic [2:0] {
		SMCG_ACTIVE,
		SMCG_SLEEP,
		SMCG_OSC_WAIT,
		SMCG_HOLD
	} smcg_state_t;

	smcg_state_t state;
	smcg_state_t next_state;
	smcg_pkg::smcg_mode_t mode;
	smcg_pkg::smcg_mode_t slept_mode;
	logic sleep_arm_bit;
	logic [15:0] osc_count;
	logic [3:0] hold_count;
	logic wake_event;
	logic [5:0] async_wake;
	logic pr_gate_active;
	logic adc_was_on;
	logic next_osc_en;
	logic next_io_en;
	logic next_adc_en;

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	smcg_sync #(
		.WIDTH(6)
	) u_sync (
		.core_clk(core_clk),
		.rst(rst),
		.async_in({external_irq_zero, pin_change_irq, wdt_irq, serial_start_frame, usi_start_cond,
			twi_addr_match}),
		.sync_out(async_wake)
	);

	// ----------------------------------------
	// control registers
	// ----------------------------------------
	assign mode = smcg_pkg::smcg_mode_t'(mcu_control_reg[smcg_pkg::SMCG_MODE_HI:smcg_pkg::SMCG_MODE_LO]);
	assign sleep_arm_bit = mcu_control_reg[smcg_pkg::SMCG_ARM_BIT];

	always_ff @(posedge core_clk) begin
		if (rst) begin
			mcu_control_reg <= smcg_pkg::SMCG_CTRL_RESET;
		end else if (mcu_ctrl_wr) begin
			mcu_control_reg <= mcu_ctrl_wdata & smcg_pkg::SMCG_CTRL_WMASK;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			power_reduction_reg <= smcg_pkg::SMCG_PRR_RESET;
		end else if (pr_wr) begin
			power_reduction_reg <= pr_wdata & smcg_pkg::SMCG_PRR_WMASK;
		end
	end

	// ----------------------------------------
	// wake qualification
	// ----------------------------------------
	always_comb begin
		wake_event = 1'b0;
		unique case (slept_mode)
			smcg_pkg::SMCG_MODE_IDLE: begin
				wake_event = irq_any_enabled | (|async_wake) | adc_done_irq | mem_ready_irq
					| (comparator_irq & ~comparator_disable_bit);
			end
			// deeper modes: irq zero counts only as a level, its edge detector has no clock
			smcg_pkg::SMCG_MODE_NOISE: begin
				wake_event = (async_wake[5] & ext_irq_level_mode) | (|async_wake[4:0])
					| adc_done_irq | mem_ready_irq;
			end
			smcg_pkg::SMCG_MODE_PDOWN, smcg_pkg::SMCG_MODE_STBY: begin
				wake_event = (async_wake[5] & ext_irq_level_mode) | (|async_wake[4:0]);
			end
		endcase
	end

	// ----------------------------------------
	// sleep sequencer
	// ----------------------------------------
	always_comb begin
		next_state = state;
		unique case (state)
			SMCG_ACTIVE: begin
				if (sleep_instr && sleep_arm_bit) begin
					next_state = SMCG_SLEEP;
				end
			end
			SMCG_SLEEP: begin
				if (wake_event) begin
					next_state = (slept_mode == smcg_pkg::SMCG_MODE_PDOWN) ? SMCG_OSC_WAIT : SMCG_HOLD;
				end
			end
			// only power-down restarts the oscillator from cold
			SMCG_OSC_WAIT: begin
				if (osc_count == 16'h0001) begin
					next_state = SMCG_HOLD;
				end
			end
			SMCG_HOLD: begin
				if (hold_count == 4'h1) begin
					next_state = SMCG_ACTIVE;
				end
			end
			default: begin
				next_state = SMCG_ACTIVE;
			end
		endcase
	end

	// reset always returns to active: the core restarts at its reset vector
	always_ff @(posedge core_clk) begin
		if (rst) begin
			state <= SMCG_ACTIVE;
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			slept_mode <= smcg_pkg::SMCG_MODE_IDLE;
		end else if (state == SMCG_ACTIVE && next_state == SMCG_SLEEP) begin
			slept_mode <= mode;
		end
	end

	// start-up count: loaded on every wake, counted down only while the oscillator restarts
	always_ff @(posedge core_clk) begin
		if (rst) begin
			osc_count <= 16'h0000;
		end else if (state == SMCG_SLEEP && wake_event) begin
			osc_count <= OSC_START_CYCLES;
		end else if (state == SMCG_OSC_WAIT && osc_count != 16'h0000) begin
			osc_count <= osc_count - 16'h0001;
		end
	end

	// standby: hold stretched so wake finishes in six cycles
	always_ff @(posedge core_clk) begin
		if (rst) begin
			hold_count <= 4'h0;
		end else if (state == SMCG_SLEEP && wake_event) begin
			hold_count <= (slept_mode == smcg_pkg::SMCG_MODE_STBY) ?
				smcg_pkg::SMCG_STBY_WAKE_CYCLES : smcg_pkg::SMCG_HOLD_CYCLES;
		end else if (state == SMCG_HOLD && hold_count != 4'h0) begin
			hold_count <= hold_count - 4'h1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			wake_irq <= 1'b0;
			wake_reset <= 1'b1;
		end else begin
			wake_irq <= (state == SMCG_HOLD && hold_count == 4'h1);
			wake_reset <= 1'b0;
		end
	end

	// ----------------------------------------
	// clock domain gating
	// ----------------------------------------
	// domain enables for the coming cycle; peripheral gates follow them on the same edge
	always_comb begin
		next_osc_en = 1'b1;
		next_io_en = (next_state != SMCG_OSC_WAIT);
		next_adc_en = (next_state != SMCG_OSC_WAIT);
		if (next_state == SMCG_SLEEP) begin
			// on the entry edge the captured mode is not loaded yet, so the live field decides
			unique case ((state == SMCG_SLEEP) ? slept_mode : mode)
				smcg_pkg::SMCG_MODE_IDLE: begin
					next_osc_en = 1'b1;
					next_io_en = 1'b1;
					next_adc_en = 1'b1;
				end
				smcg_pkg::SMCG_MODE_NOISE: begin
					next_osc_en = 1'b1;
					next_io_en = 1'b0;
					next_adc_en = 1'b1;
				end
				smcg_pkg::SMCG_MODE_PDOWN: begin
					next_osc_en = 1'b0;
					next_io_en = 1'b0;
					next_adc_en = 1'b0;
				end
				smcg_pkg::SMCG_MODE_STBY: begin
					next_osc_en = 1'b1;
					next_io_en = 1'b0;
					next_adc_en = 1'b0;
				end
			endcase
		end
	end

	// only clock enables are gated; storage keeps its contents across sleep
	always_ff @(posedge core_clk) begin
		if (rst) begin
			osc_en <= 1'b1;
			clk_cpu_en <= 1'b1;
			clk_flash_en <= 1'b1;
			clk_io_en <= 1'b1;
			clk_adc_en <= 1'b1;
		end else begin
			osc_en <= next_osc_en;
			clk_cpu_en <= (next_state == SMCG_ACTIVE);
			clk_flash_en <= (next_state == SMCG_ACTIVE);
			clk_io_en <= next_io_en;
			clk_adc_en <= next_adc_en;
		end
	end

	assign sleeping = (state == SMCG_SLEEP);
	assign cpu_halt = (state != SMCG_ACTIVE);

	// ----------------------------------------
	// per-peripheral gating
	// ----------------------------------------
	// stop bits other than the converter's only matter while io clock runs; deeper modes already stop it
	assign pr_gate_active = next_io_en;
	always_ff @(posedge core_clk) begin
		if (rst) begin
			clk_twi_en <= 1'b1;
			clk_tim1_en <= 1'b1;
			clk_tim0_en <= 1'b1;
			clk_usi_en <= 1'b1;
			clk_ser1_en <= 1'b1;
			clk_ser0_en <= 1'b1;
			clk_conv_en <= 1'b1;
			periph_access_en <= 7'h7F;
		end else begin
			clk_twi_en <= pr_gate_active & ~power_reduction_reg[smcg_pkg::SMCG_PR_TWI];
			clk_tim1_en <= pr_gate_active & ~power_reduction_reg[smcg_pkg::SMCG_PR_TIM1];
			clk_tim0_en <= pr_gate_active & ~power_reduction_reg[smcg_pkg::SMCG_PR_TIM0];
			clk_usi_en <= pr_gate_active & ~power_reduction_reg[smcg_pkg::SMCG_PR_USI];
			clk_ser1_en <= pr_gate_active & ~power_reduction_reg[smcg_pkg::SMCG_PR_SER1];
			clk_ser0_en <= pr_gate_active & ~power_reduction_reg[smcg_pkg::SMCG_PR_SER0];
			clk_conv_en <= next_adc_en & ~power_reduction_reg[smcg_pkg::SMCG_PR_ADC];
			periph_access_en <= ~power_reduction_reg[6:0];
		end
	end

	// ----------------------------------------
	// converter and comparator
	// ----------------------------------------
	always_ff @(posedge core_clk) begin
		if (rst) begin
			adc_start_conv <= 1'b0;
			adc_was_on <= 1'b0;
			adc_extended_next <= 1'b1;
			comparator_power_en <= 1'b0;
		end else begin
			adc_start_conv <= (state == SMCG_ACTIVE) && (next_state == SMCG_SLEEP) && adc_enabled
				&& (mode == smcg_pkg::SMCG_MODE_IDLE || mode == smcg_pkg::SMCG_MODE_NOISE);
			adc_was_on <= adc_enabled;
			if (adc_enabled && !adc_was_on) begin
				adc_extended_next <= 1'b1;
			end else if (adc_start_conv) begin
				adc_extended_next <= 1'b0;
			end
			comparator_power_en <= ~comparator_disable_bit;
		end
	end
endmodule
`default_nettype wire

// ---- testbench/smcg_level_src.sv ----
`timescale 1ns/1ps
`default_nettype none
module smcg_level_src (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// trigger and core answer
	input wire logic trigger,
	input wire logic wake_irq,
	// level line
	output logic level
);
	// level stays active until the handler is entered
	always_ff @(posedge core_clk) begin
		if (rst || wake_irq) level <= 1'b0;
		else if (trigger) level <= 1'b1;
	end
endmodule
`default_nettype wire

// ---- testbench/smcg_ctrl_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
module smcg_ctrl_asserts (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// core side
	input wire logic sleep_instr,
	input wire logic adc_enabled,
	input wire logic comparator_disable_bit,
	input wire logic [7:0] mcu_control_reg,
	input wire logic [7:0] power_reduction_reg,
	input wire logic cpu_halt,
	input wire logic sleeping,
	input wire logic wake_irq,
	input wire logic wake_reset,
	input wire logic adc_start_conv,
	input wire logic comparator_power_en,
	// clock gates
	input wire logic osc_en,
	input wire logic clk_cpu_en,
	input wire logic clk_flash_en,
	input wire logic clk_io_en,
	input wire logic clk_adc_en,
	input wire logic clk_twi_en,
	input wire logic clk_tim1_en,
	input wire logic clk_tim0_en,
	input wire logic clk_usi_en,
	input wire logic clk_ser1_en,
	input wire logic clk_ser0_en,
	input wire logic clk_conv_en,
	input wire logic [6:0] periph_access_en
);
	logic [1:0] md;
	logic [4:0] dom;
	logic [6:0] pg;
	assign md = mcu_control_reg[6:5];
	assign dom = {osc_en, clk_cpu_en, clk_flash_en, clk_io_en, clk_adc_en};
	assign pg = {clk_twi_en, clk_tim1_en, clk_tim0_en, clk_usi_en, clk_ser1_en, clk_ser0_en, clk_conv_en};
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	chk_reset_exit: assert property ($fell(rst) |-> wake_reset && power_reduction_reg == 8'h00 && dom == 5'h1F)
		else $error("reset state wrong");
	chk_prr_top: assert property (power_reduction_reg[7] == 1'b0) else $error("prr bit 7 set");
	chk_access_map: assert property ($stable(power_reduction_reg)
		|-> periph_access_en == ~power_reduction_reg[6:0]) else $error("access map wrong");
	chk_idle_domains: assert property (sleeping && md == 2'h0 |-> dom == 5'h13) else $error("idle gates");
	chk_noise_domains: assert property (sleeping && md == 2'h1 |-> dom == 5'h11) else $error("noise gates");
	chk_pdown_domains: assert property ($rose(sleeping) && md == 2'h2 |-> dom == 5'h00) else $error("pdown gates");
	chk_stby_domains: assert property ($rose(sleeping) && md == 2'h3 |-> dom == 5'h10) else $error("stby gates");
	chk_arm_refuse: assert property (sleep_instr && !mcu_control_reg[4] && !cpu_halt |=> !cpu_halt)
		else $error("slept unarmed");
	chk_arm_enter: assert property (sleep_instr && mcu_control_reg[4] && !cpu_halt |=> sleeping && cpu_halt)
		else $error("no sleep");
	chk_idle_hold: assert property ($fell(sleeping) && md == 2'h0 |-> cpu_halt [*4] ##1 (!cpu_halt && wake_irq))
		else $error("idle hold");
	chk_stby_hold: assert property ($fell(sleeping) && md == 2'h3 |-> cpu_halt [*6] ##1 !cpu_halt)
		else $error("stby hold");
	chk_conv_start: assert property ($rose(sleeping) && adc_enabled && !md[1] |-> ##[0:2] adc_start_conv)
		else $error("no conversion");
	chk_gate_map: assert property ($stable(power_reduction_reg) && $stable(cpu_halt) && !cpu_halt
		|-> pg == ~power_reduction_reg[6:0]) else $error("gate map");
	chk_deep_gates: assert property ($rose(sleeping) && md[1] |-> pg == 7'h00) else $error("deep gates");
	chk_comp_off: assert property (comparator_disable_bit && $past(comparator_disable_bit) |-> !comparator_power_en)
		else $error("comparator on");
	chk_wake_pulse: assert property ($rose(wake_irq) |=> !wake_irq) else $error("wake pulse");
endmodule
`default_nettype wire

// ---- testbench/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin err_total++; $display("BAD %s exp %0h got %0h", nm, e, g); end end
module tb_top;
	localparam logic [15:0] OSC = 16'h0003;
	logic core_clk = 1'b0, rst = 1'b1, mcu_ctrl_wr = 1'b0, pr_wr = 1'b0, sleep_instr = 1'b0, adc_enabled = 1'b0;
	logic comparator_disable_bit = 1'b0, irq_any_enabled = 1'b0, ext_irq_level_mode = 1'b0, trig = 1'b0;
	logic adc_done_irq = 1'b0, mem_ready_irq = 1'b0, twi_addr_match = 1'b0, pin_change_irq = 1'b0;
	logic wdt_irq = 1'b0, serial_start_frame = 1'b0, usi_start_cond = 1'b0, comparator_irq = 1'b0;
	logic [7:0] mcu_ctrl_wdata = 8'h00, pr_wdata = 8'h00, mcu_control_reg, power_reduction_reg;
	logic cpu_halt, sleeping, wake_irq, wake_reset, adc_start_conv, adc_extended_next, comparator_power_en;
	logic osc_en, clk_cpu_en, clk_flash_en, clk_io_en, clk_adc_en, external_irq_zero;
	logic clk_twi_en, clk_tim1_en, clk_tim0_en, clk_usi_en, clk_ser1_en, clk_ser0_en, clk_conv_en;
	logic [6:0] periph_access_en;
	wire logic [6:0] gate_bits = {clk_twi_en, clk_tim1_en, clk_tim0_en, clk_usi_en, clk_ser1_en, clk_ser0_en, clk_conv_en};
	logic [31:0] rnd = 32'h9C12;
	int err_total = 0, num_checks = 0, hc = 0, exp_hold;
	int hold_q[$];
	smcg_ctrl #(.OSC_START_CYCLES(OSC)) DUT (.*);
	smcg_level_src ext_src (.core_clk(core_clk), .rst(rst), .trigger(trig), .wake_irq(wake_irq), .level(external_irq_zero));
	initial forever #50 core_clk = ~core_clk;
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	task automatic test_done;
		if (err_total == 0 && num_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic wr(input bit sel, input logic [7:0] v);
		@(posedge core_clk);
		if (sel) pr_wr <= 1'b1;
		else mcu_ctrl_wr <= 1'b1;
		pr_wdata <= v;
		mcu_ctrl_wdata <= v;
		@(posedge core_clk);
		pr_wr <= 1'b0;
		mcu_ctrl_wr <= 1'b0;
	endtask
	task automatic sleep_go;
		@(posedge core_clk);
		sleep_instr <= 1'b1;
		@(posedge core_clk);
		sleep_instr <= 1'b0;
	endtask
	task automatic wait_wake;
		int n;
		for (n = 0; n < 300 && wake_irq !== 1'b1; n++) @(posedge core_clk);
		if (n == 300) begin
			err_total++;
			test_done;
		end
	endtask
	// hold length seen by the core, compared against the note of the driver
	always @(posedge core_clk) begin
		if (rst || sleeping) hc = 0;
		else if (cpu_halt) hc = hc + 1;
		if (wake_irq === 1'b1) begin
			exp_hold = hold_q.size() ? hold_q.pop_front() : -1;
			`CHK("hold", exp_hold, hc)
		end
	end
	initial begin
		tick(12);
		rst <= 1'b0;
		#1 `CHK("prr", 8'h00, power_reduction_reg)
		rnd = xs(rnd);
		wr(1'b1, rnd[7:0] | 8'h80);
		#1 `CHK("prr", rnd[7:0] & 8'h7F, power_reduction_reg)
		tick(2);
		#1 `CHK("access", ~rnd[6:0], periph_access_en)
		`CHK("gates", ~rnd[6:0], gate_bits)
		wr(1'b1, 8'h00);
		tick(2);
		#1 `CHK("gates", 7'h7F, gate_bits)
		tick(1);
		adc_enabled <= 1'b1;
		tick(2);
		adc_enabled <= 1'b0;
		tick(2);
		adc_enabled <= 1'b1;
		tick(2);
		#1 `CHK("extended", 1'b1, adc_extended_next)
		wr(1'b0, 8'h00);
		sleep_go;
		#1 `CHK("halt", 1'b0, cpu_halt)
		for (int m = 0; m < 4; m++) begin
			tick(1);
			adc_enabled <= (m < 2);
			comparator_disable_bit <= (m == 0);
			ext_irq_level_mode <= 1'b1;
			wr(1'b0, 8'h10 | 8'(m << 5) | 8'h8F);
			#1 `CHK("ctrl", 8'h10 | 8'(m << 5), mcu_control_reg)
			sleep_go;
			#1 `CHK("sleep", 1'b1, sleeping)
			`CHK("cpu clk", 1'b0, clk_cpu_en)
			if (m == 1) `CHK("extended", 1'b0, adc_extended_next)
			if (m == 0) begin
				`CHK("comp", 1'b0, comparator_power_en)
				tick(1);
				comparator_irq <= 1'b1;
				tick(3);
				#1 `CHK("comp wake", 1'b1, sleeping)
				tick(1);
				comparator_irq <= 1'b0;
			end
			if (m >= 2) begin
				tick(1);
				adc_done_irq <= 1'b1;
				mem_ready_irq <= 1'b1;
				tick(8);
				#1 `CHK("ignored", 1'b1, sleeping)
				tick(1);
				adc_done_irq <= 1'b0;
				mem_ready_irq <= 1'b0;
			end
			hold_q.push_back(m == 3 ? 6 : m == 2 ? int'(OSC) + 4 : 4);
			tick(1);
			case (m)
				0: irq_any_enabled <= 1'b1;
				1: adc_done_irq <= 1'b1;
				2: trig <= 1'b1;
				default: twi_addr_match <= 1'b1;
			endcase
			tick(1);
			trig <= 1'b0;
			wait_wake;
			irq_any_enabled <= 1'b0;
			adc_done_irq <= 1'b0;
			twi_addr_match <= 1'b0;
			#1 `CHK("cpu clk", 1'b1, clk_cpu_en)
		end
		tick(1);
		adc_enabled <= 1'b1;
		tick(2);
		#1 `CHK("extended", 1'b1, adc_extended_next)
		wr(1'b0, 8'h50);
		sleep_go;
		tick(2);
		rst <= 1'b1;
		tick(3);
		rst <= 1'b0;
		#1 `CHK("vector", 1'b1, wake_reset)
		`CHK("halt", 1'b0, cpu_halt)
		tick(10);
		test_done;
	end
endmodule
bind smcg_ctrl smcg_ctrl_asserts chk (.*);
`default_nettype wire
